// [rtl/dac_clock_pll_band_control.sv]
`default_nettype none
`include "pll_regs.svh"
module dac_clock_pll_band_control
    import pll_pkg::*;
#(
    parameter int SETTLE = `SETTLE_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            regRdValid,
    input  wire logic       pllLockPin,
    input  wire logic [3:0] vcoVoltPin,
    output logic            pllEnable,
    output logic            pllPowerDown,
    output logic      [5:0] vcoBand,
    output logic      [1:0] loopBandwidth,
    output logic      [4:0] chargePumpCurrent,
    output logic            crossControlEn,
    output logic            dutyCycleCorrEn,
    output logic            levelCorrEn,
    output logic            bandSearchBusy,
    output logic            moveHigherBand,
    output logic            moveLowerBand,
    output logic            vcoOptimal
);

    logic [7:0] clkRx_q;
    logic [7:0] pllCtrl_q;
    logic [7:0] pllLoop_q;
    logic [7:0] pllCross_q;
    logic       autoArmed_q;
    logic       searchStart_q;
    logic       lockSync;
    logic [3:0] voltSync;
    logic [5:0] searchBand;
    logic       searchBusy;
    logic       wrCtrl;
    vco_hint_t  hint;

    assign wrCtrl = regWrite && regAddr == `REG_PLL_CTRL;
    assign hint   = classifyVolt(voltSync);

    // Analog lock and voltage arrive with no relation to core_clk
    pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .pinIn    ({pllLockPin, vcoVoltPin}),
        .pinOut   ({lockSync, voltSync})
    );

    vco_band_search #(
        .SETTLE (SETTLE)
    ) u_search (
        .core_clk (core_clk),
        .srst     (srst),
        .start    (searchStart_q),
        .locked   (lockSync),
        .voltCode (voltSync),
        .band     (searchBand),
        .busy     (searchBusy)
    );

    // Clock receiver correction enables
    always_ff @(posedge core_clk)
    begin
        if (srst)
            clkRx_q <= `CLK_RX_RST;
        else if (regWrite && regAddr == `REG_CLK_RX)
        begin
            clkRx_q <= 8'h00;
            clkRx_q[`DUTY_CORR_BIT]  <= regWdata[`DUTY_CORR_BIT];
            clkRx_q[`LEVEL_CORR_BIT] <= regWdata[`LEVEL_CORR_BIT];
        end
    end

    // PLL enable, manual band enable and band field
    always_ff @(posedge core_clk)
    begin
        if (srst)
            pllCtrl_q <= `PLL_CTRL_RST;
        else if (wrCtrl)
            pllCtrl_q <= regWdata;
    end

    // Loop settings; bit 5 is reserved and kept at zero
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pllLoop_q  <= `PLL_LOOP_RST;
            pllCross_q <= `PLL_CROSS_RST;
        end
        else if (regWrite && regAddr == `REG_PLL_LOOP)
            pllLoop_q <= {regWdata[7:6], 1'b0, regWdata[4:0]};
        else if (regWrite && regAddr == `REG_PLL_CROSS)
            pllCross_q <= {3'h0, regWdata[`CROSS_EN_BIT], 4'h0};
    end

    // Arm on the manual-mode value, fire on the auto-mode value that follows.
    // Any other control write in between drops the arming, so a stray
    // write cannot start a search by accident.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            autoArmed_q   <= 1'b0;
            searchStart_q <= 1'b0;
        end
        else
        begin
            searchStart_q <= 1'b0;
            if (wrCtrl)
            begin
                autoArmed_q <= (regWdata == `AUTO_ARM_VAL);
                if (autoArmed_q && regWdata == `AUTO_GO_VAL)
                    searchStart_q <= 1'b1;
            end
        end
    end

    // Clock source and multiplier power. The multiplied frequencies follow
    // the two divider factors in the analog loop; logic only picks the source.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pllEnable    <= 1'b0;
            pllPowerDown <= 1'b1;
        end
        else
        begin
            pllEnable    <= pllCtrl_q[`PLL_EN_BIT];
            pllPowerDown <= !pllCtrl_q[`PLL_EN_BIT];
        end
    end

    // Band: manual field when enabled, else the search result
    always_ff @(posedge core_clk)
    begin
        if (srst)
            vcoBand <= `BAND_START;
        else if (pllCtrl_q[`MANUAL_BIT])
            vcoBand <= pllCtrl_q[5:0];
        else
            vcoBand <= searchBand;
    end

    // Loop and receiver settings to the analog side
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            loopBandwidth     <= 2'h0;
            chargePumpCurrent <= 5'h00;
            crossControlEn    <= 1'b0;
            dutyCycleCorrEn   <= 1'b0;
            levelCorrEn       <= 1'b0;
        end
        else
        begin
            loopBandwidth     <= pllLoop_q[7:6];
            chargePumpCurrent <= pllLoop_q[4:0];
            crossControlEn    <= pllCross_q[`CROSS_EN_BIT];
            dutyCycleCorrEn   <= clkRx_q[`DUTY_CORR_BIT];
            levelCorrEn       <= clkRx_q[`LEVEL_CORR_BIT];
        end
    end

    // Band position hints from the synchronised voltage code
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            moveHigherBand <= 1'b0;
            moveLowerBand  <= 1'b0;
            vcoOptimal     <= 1'b0;
            bandSearchBusy <= 1'b0;
        end
        else
        begin
            moveHigherBand <= (hint == HINT_UP);
            moveLowerBand  <= (hint == HINT_DOWN);
            vcoOptimal     <= (hint == HINT_OPT);
            bandSearchBusy <= searchBusy || searchStart_q;
        end
    end

    // Register readback, one cycle after the read strobe
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            regRdata   <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead;
            regRdata   <= 8'h00;
            if (regRead)
            begin
                unique case (regAddr)
                    `REG_CLK_RX:    regRdata <= clkRx_q;
                    `REG_PLL_CTRL:  regRdata <= pllCtrl_q;
                    `REG_PLL_LOOP:  regRdata <= pllLoop_q;
                    `REG_PLL_CROSS: regRdata <= pllCross_q;
                    `REG_VCO_VOLT:
                        regRdata <= {searchBusy || searchStart_q, lockSync,
                                     2'h0, voltSync};
                    default:        regRdata <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    chk_pll_off_direct: assert property (
        !pllCtrl_q[`PLL_EN_BIT] |=> pllPowerDown && !pllEnable)
        else $error("direct clock not selected with PLL disabled");

    chk_pll_on_mult: assert property (
        wrCtrl && regWdata[`PLL_EN_BIT] |=> ##1 pllEnable && !pllPowerDown)
        else $error("multiplier not selected after enable write");

    chk_manual_band_use: assert property (
        wrCtrl && regWdata[`MANUAL_BIT] |=> ##1
            vcoBand == $past(regWdata[5:0], 2))
        else $error("manual band value not applied");

    chk_volt_read_back: assert property (
        regRead && regAddr == `REG_VCO_VOLT |=>
            regRdValid && regRdata[3:0] == $past(voltSync))
        else $error("voltage code readback wrong");

    chk_higher_band_hint: assert property (
        voltSync[3:1] == 3'h7 |=> moveHigherBand && !vcoOptimal)
        else $error("higher band hint missing");

    chk_lower_band_hint: assert property (
        voltSync[3:1] == 3'h0 |=> moveLowerBand && !moveHigherBand)
        else $error("lower band hint missing");

    chk_optimal_band_hint: assert property (
        $stable(voltSync) && voltSync[3:1] == 3'h4 |=> vcoOptimal)
        else $error("optimal region not flagged");

    chk_auto_seq_start: assert property (
        wrCtrl && autoArmed_q && regWdata == `AUTO_GO_VAL |=>
            searchStart_q ##1 bandSearchBusy)
        else $error("auto band search did not start");

    chk_rx_corr_bits: assert property (
        regWrite && regAddr == `REG_CLK_RX |=> ##1
            dutyCycleCorrEn == $past(regWdata[`DUTY_CORR_BIT], 2))
        else $error("duty cycle correction enable wrong");

    // Guards on the arming pair, band source and mirrored settings
    chk_stray_no_start: assert property (
        wrCtrl && !(autoArmed_q && regWdata == `AUTO_GO_VAL) |=>
            !searchStart_q)
        else $error("search started without the arming pair");

    chk_auto_band_use: assert property (
        !pllCtrl_q[`MANUAL_BIT] |=>
            vcoBand == $past(searchBand))
        else $error("search band not applied in auto mode");

    chk_power_up_pll: assert property (
        pllCtrl_q[`PLL_EN_BIT] |=>
            pllEnable && !pllPowerDown)
        else $error("multiplier not selected while enabled");

    chk_loop_bw_out: assert property (
        regWrite && regAddr == `REG_PLL_LOOP |=> ##1
            loopBandwidth == $past(regWdata[7:6], 2))
        else $error("loop bandwidth setting not applied");

    chk_pump_cur_out: assert property (
        regWrite && regAddr == `REG_PLL_LOOP |=> ##1
            chargePumpCurrent == $past(regWdata[4:0], 2))
        else $error("charge pump setting not applied");

    chk_cross_ctrl_out: assert property (
        regWrite && regAddr == `REG_PLL_CROSS |=> ##1
            crossControlEn == $past(regWdata[`CROSS_EN_BIT], 2))
        else $error("cross control enable not applied");

    chk_level_corr_bit: assert property (
        regWrite && regAddr == `REG_CLK_RX |=> ##1
            levelCorrEn == $past(regWdata[`LEVEL_CORR_BIT], 2))
        else $error("level correction enable wrong");

    chk_volt_upper_zero: assert property (
        regRead && regAddr == `REG_VCO_VOLT |=>
            regRdValid && regRdata[5:4] == 2'h0)
        else $error("unused voltage readback bits not zero");

    chk_ctrl_read_back: assert property (
        regRead && regAddr == `REG_PLL_CTRL |=>
            regRdValid && regRdata == $past(pllCtrl_q))
        else $error("control register readback wrong");

endmodule
`default_nettype wire

// [rtl/pin_sync.sv]
`default_nettype none
module pin_sync
    import pll_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;

    // Three stages; the second and third both feed the agreement check besides the chain
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end
        else
        begin
            stage1_q <= pinIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // Accept a change only once two late stages agree
    always_ff @(posedge core_clk)
    begin
        if (srst)
            pinOut <= '0;
        else if (stage2_q == stage3_q)
            pinOut <= stage3_q;
    end

endmodule
`default_nettype wire

// [rtl/pll_pkg.sv]
`default_nettype none
package pll_pkg;

    // Where the VCO sits inside its current band
    typedef enum logic [2:0] {
        HINT_UP,
        HINT_HIGH,
        HINT_OPT,
        HINT_LOW,
        HINT_DOWN
    } vco_hint_t;

    typedef enum logic [1:0] {
        SRCH_IDLE,
        SRCH_SETTLE,
        SRCH_CHECK
    } search_state_t;

    // Classify the 4-bit control voltage code
    function automatic vco_hint_t classifyVolt(input logic [3:0] code);
        vco_hint_t h;
        if (code >= 4'hE)
            h = HINT_UP;
        else if (code >= 4'hA)
            h = HINT_HIGH;
        else if (code >= 4'h8)
            h = HINT_OPT;
        else if (code >= 4'h2)
            h = HINT_LOW;
        else
            h = HINT_DOWN;
        return h;
    endfunction

endpackage
`default_nettype wire

// [rtl/pll_regs.svh]
// How it works
// - PLL enable low powers the multiplier down and selects the direct clock pins.
// - PLL enable high makes the sample clock come from the reference via multiplier.
// - VCO runs at reference times both factors; sample clock at reference times first.
// - After that pair of writes the device searches a band alone, with no host help.
// - With manual enable set, the 6-bit band field drives the VCO band directly.
// - The 4-bit VCO control voltage code reads back in register vco_control_voltage_readback bits 3:0.
// - Codes 1111 and 1110 mean a higher VCO band should be chosen.
// - Codes 0001 and 0000 mean a lower VCO band should be chosen.
// - Codes 1001 and 1000 mean the VCO sits in the middle of its band.
// - Register 0x08 holds enables for duty cycle and input level correction.
`ifndef PLL_REGS_SVH
`define PLL_REGS_SVH

// Register offsets
`define REG_CLK_RX      8'h08
`define REG_PLL_CTRL    8'h0A
`define REG_PLL_LOOP    8'h0C
`define REG_PLL_CROSS   8'h0D
`define REG_VCO_VOLT    8'h0E

// Field positions
`define PLL_EN_BIT      7
`define MANUAL_BIT      6
`define CROSS_EN_BIT    4
`define DUTY_CORR_BIT   0
`define LEVEL_CORR_BIT  1
`define LOCK_BIT        6
`define BUSY_BIT        7

// Reset values
`define CLK_RX_RST      8'h00
`define PLL_CTRL_RST    8'h00
`define PLL_LOOP_RST    8'h00
`define PLL_CROSS_RST   8'h00

// Auto band select write pair
`define AUTO_ARM_VAL    8'hCF
`define AUTO_GO_VAL     8'hA0

// Band search
`define BAND_LAST       6'h3E
`define BAND_START      6'h1F

// Timing
`define CLK_PERIOD_NS   50
// Edges from a band step until the synced code shows it: band register,
// three synchroniser stages and the agreement stage
`define SYNC_PIPE       5
`define SETTLE_TIME_NS  10000
`define SETTLE_CYCLES   \
    ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/vco_band_search.sv]
`default_nettype none
`include "pll_regs.svh"
module vco_band_search
    import pll_pkg::*;
#(
    parameter int SETTLE = `SETTLE_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic       locked,
    input  wire logic [3:0] voltCode,
    output logic      [5:0] band,
    output logic            busy
);

    search_state_t state_q;
    logic [15:0]   settle_q;
    logic [5:0]    tries_q;
    vco_hint_t     hint;

    assign hint = classifyVolt(voltCode);

    // Walk bands toward the one whose voltage sits mid band
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q  <= SRCH_IDLE;
            settle_q <= 16'h0000;
            tries_q  <= 6'h00;
            band     <= `BAND_START;
            busy     <= 1'b0;
        end
        else if (start)
        begin
            state_q  <= SRCH_SETTLE;
            settle_q <= 16'h0000;
            tries_q  <= 6'h00;
            band     <= `BAND_START;
            busy     <= 1'b1;
        end
        else
        begin
            unique case (state_q)
                SRCH_IDLE:
                    busy <= 1'b0;
                SRCH_SETTLE:
                begin
                    // Loop needs time to settle, then the code must crawl
                    // through the band register and synchroniser; judging
                    // earlier would act on the previous band's code
                    if (settle_q == 16'(SETTLE + `SYNC_PIPE - 1))
                        state_q <= SRCH_CHECK;
                    else
                        settle_q <= settle_q + 16'h0001;
                end
                SRCH_CHECK:
                begin
                    settle_q <= 16'h0000;
                    tries_q  <= tries_q + 6'h01;
                    state_q  <= SRCH_SETTLE;
                    if ((locked && hint == HINT_OPT)
                        || tries_q == `BAND_LAST)
                    begin
                        state_q <= SRCH_IDLE;
                        busy    <= 1'b0;
                    end
                    else if (hint == HINT_LOW || hint == HINT_DOWN)
                    begin
                        if (band != 6'h00)
                            band <= band - 6'h01;
                        else
                            state_q <= SRCH_IDLE;
                    end
                    else if (band != `BAND_LAST)
                        band <= band + 6'h01;
                    else
                        state_q <= SRCH_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// [test/pll_analog_model.sv]
`default_nettype none
module pll_analog_model
#(
    parameter logic [5:0] TARGET = 6'h25
) (
    input  wire logic       pllPowerDown,
    input  wire logic [5:0] vcoBand,
    output logic            pllLockPin,
    output logic      [3:0] vcoVoltPin
);
    timeunit 1ns;
    timeprecision 1ns;

    int diff;

    // Code climbs as the band drops below the fitting one; lock is narrow
    always_comb
    begin
        diff = int'(TARGET) - int'(vcoBand);
        if (diff > 7)
            vcoVoltPin = 4'hF;
        else if (diff < -8)
            vcoVoltPin = 4'h0;
        else
            vcoVoltPin = 4'(8 + diff);
        // A powered-down loop never claims lock
        pllLockPin = !pllPowerDown && diff <= 2 && diff >= -2;
    end
endmodule
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pll_pkg::*;

    // Fitting band sits well inside the 63 usable bands
    localparam logic [5:0] TARGET = 6'h25;

    logic       core_clk = 1'b0;
    logic       srst = 1'b1;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic       regRdValid;
    logic       pllLockPin;
    logic [3:0] vcoVoltPin;
    logic       pllEnable;
    logic       pllPowerDown;
    logic [5:0] vcoBand;
    logic [1:0] loopBandwidth;
    logic [4:0] chargePumpCurrent;
    logic       crossControlEn;
    logic       dutyCycleCorrEn;
    logic       levelCorrEn;
    logic       bandSearchBusy;
    logic       moveHigherBand;
    logic       moveLowerBand;
    logic       vcoOptimal;
    int         errors = 0;
    int         samples_checked = 0;

    dac_clock_pll_band_control #(.SETTLE(4)) dut_u (
        .core_clk(core_clk), .srst(srst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regRdValid(regRdValid),
        .pllLockPin(pllLockPin), .vcoVoltPin(vcoVoltPin),
        .pllEnable(pllEnable), .pllPowerDown(pllPowerDown),
        .vcoBand(vcoBand), .loopBandwidth(loopBandwidth),
        .chargePumpCurrent(chargePumpCurrent),
        .crossControlEn(crossControlEn), .dutyCycleCorrEn(dutyCycleCorrEn),
        .levelCorrEn(levelCorrEn), .bandSearchBusy(bandSearchBusy),
        .moveHigherBand(moveHigherBand), .moveLowerBand(moveLowerBand),
        .vcoOptimal(vcoOptimal)
    );

    pll_analog_model #(.TARGET(TARGET)) far_u (
        .pllPowerDown(pllPowerDown), .vcoBand(vcoBand),
        .pllLockPin(pllLockPin), .vcoVoltPin(vcoVoltPin)
    );

    // 20 MHz system clock
    always #25 core_clk = ~core_clk;

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Strobes last one cycle; a gap cycle keeps each strobe edge distinct
    task automatic regWr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        regWrite = 1'b1;
        regAddr = addr;
        regWdata = data;
        @(negedge core_clk);
        regWrite = 1'b0;
    endtask

    task automatic regRd(input logic [7:0] addr, input logic [7:0] exp);
        @(negedge core_clk);
        regRead = 1'b1;
        regAddr = addr;
        @(negedge core_clk);
        regRead = 1'b0;
        check("read valid", 8'h01, {7'h00, regRdValid});
        check($sformatf("reg %h", addr), exp, regRdata);
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic test_reset();
        check("power down", 8'h01, {7'h00, pllPowerDown});
        check("band", 8'h1F, {2'b00, vcoBand});
        regRd(8'h08, 8'h00);
        regRd(8'h0A, 8'h00);
        regRd(8'h0C, 8'h00);
        regRd(8'h20, 8'h00);
        $display("test_reset done");
    endtask

    task automatic test_source();
        regWr(8'h0A, 8'h80);
        waitCyc(2);
        check("enable", 8'h01, {7'h00, pllEnable});
        check("power down", 8'h00, {7'h00, pllPowerDown});
        regWr(8'h0A, 8'h00);
        waitCyc(2);
        check("enable", 8'h00, {7'h00, pllEnable});
        check("power down", 8'h01, {7'h00, pllPowerDown});
        $display("test_source done");
    endtask

    task automatic test_settings();
        regWr(8'h0C, 8'hF1);
        regWr(8'h0D, 8'hFF);
        regWr(8'h08, 8'hFF);
        regWr(8'h0E, 8'hFF);
        waitCyc(2);
        check("bandwidth", 8'h03, {6'h00, loopBandwidth});
        check("pump", 8'h11, {3'h0, chargePumpCurrent});
        check("cross", 8'h01, {7'h00, crossControlEn});
        check("duty", 8'h01, {7'h00, dutyCycleCorrEn});
        check("level", 8'h01, {7'h00, levelCorrEn});
        regRd(8'h0C, 8'hD1);
        regRd(8'h0D, 8'h10);
        regRd(8'h08, 8'h03);
        $display("test_settings done");
    endtask

    // Steps the band so the voltage code walks through the up, optimal and down hint classes
    task automatic test_manual();
        int diffs[6] = '{7, 6, 1, 0, -7, -8};
        logic [3:0] code;
        logic lock;
        foreach (diffs[i])
        begin
            code = 4'(8 + diffs[i]);
            lock = diffs[i] <= 2 && diffs[i] >= -2;
            regWr(8'h0A, {2'b11, 6'(int'(TARGET) - diffs[i])});
            waitCyc(10);
            check("band", {2'b00, 6'(int'(TARGET) - diffs[i])},
                  {2'b00, vcoBand});
            regRd(8'h0E, {1'b0, lock, 2'b00, code});
            check("higher", {7'h00, code >= 4'hE},
                  {7'h00, moveHigherBand});
            check("lower", {7'h00, code <= 4'h1},
                  {7'h00, moveLowerBand});
            check("optimal", {7'h00, code == 4'h8 || code == 4'h9},
                  {7'h00, vcoOptimal});
        end
        // Keep the band whose code sits mid range
        regWr(8'h0A, {2'b11, TARGET});
        waitCyc(10);
        check("chosen band", {2'b00, TARGET}, {2'b00, vcoBand});
        check("chosen optimal", 8'h01, {7'h00, vcoOptimal});
        $display("test_manual done");
    endtask

    task automatic test_auto();
        int n = 0;
        regWr(8'h0A, 8'hCF);
        regWr(8'h0A, 8'h80);
        regWr(8'h0A, 8'hA0);
        waitCyc(3);
        check("busy disarmed", 8'h00, {7'h00, bandSearchBusy});
        regWr(8'h0A, 8'hCF);
        regWr(8'h0A, 8'hA0);
        waitCyc(2);
        check("busy", 8'h01, {7'h00, bandSearchBusy});
        while (bandSearchBusy === 1'b1 && n < 1000)
        begin
            waitCyc(1);
            n++;
        end
        check("search ended", 8'h00, {7'h00, bandSearchBusy});
        waitCyc(8);
        check("auto band", {2'b00, TARGET - 6'h01}, {2'b00, vcoBand});
        regRd(8'h0E, 8'h49);
        check("optimal", 8'h01, {7'h00, vcoOptimal});
        $display("test_auto done");
    endtask

    // Cuts a hang short well past the expected few hundred cycles
    initial
    begin
        #(50 * 20000);
        errors++;
        finish_test();
    end

    initial
    begin
        waitCyc(12);
        srst = 1'b0;
        waitCyc(6);
        test_reset();
        test_source();
        test_settings();
        test_manual();
        test_auto();
        finish_test();
    end
endmodule
`default_nettype wire
